// >>> ap_port.sv
// shared pcm / i2s serial audio port: link engine and bus-side top
// assumes link_clk is the audio reference clock and that clk (100 MHz) is unrelated to it
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "ap_regs.svh"

// -------------------------------------------------------------
// link engine, runs on the link clock
// -------------------------------------------------------------
module ap_engine import ap_pkg::*;
#(
   parameter int unsigned PCM_HALF_MIN = 1 // link clocks per half bit at the top pcm rate
)
(
   input  wire logic link_clk,
   input  wire logic link_rstn,
   ap_link_if.lnk    lnk,
   input  wire logic bit_clock_i,
   input  wire logic audio_frame_clock_i,
   input  wire logic pcm_serial_in,
   output logic      bit_clock_o,
   output logic      bit_clock_oe_n,
   output logic      audio_frame_clock_o,
   output logic      audio_frame_clock_oe_n,
   output logic      master_clock_o,
   output logic      master_clock_oe_n,
   output logic      pcm_serial_out,
   output logic      pcm_serial_out_oe_n
);
   ap_eng_t     q;      // state
   ap_eng_t     n;      // next state
   ap_cfg_t     cfg;    // synchronised configuration
   logic        sd_s;   // synchronised serial input
   logic        bclk_s; // synchronised bit clock and its previous value
   logic        bclk_p;
   logic        fs_s;   // synchronised frame clock and its previous value
   logic        fs_p;
   logic        req_s;  // synchronised hand-over toggle and its previous value
   logic        req_p;
   logic [4:0]  w;      // sample width
   logic [4:0]  sl;     // slot length
   logic [11:0] len;    // bits per frame
   logic [10:0] last;   // last bit index
   logic [15:0] half;   // half bit period in link clocks
   logic        rise;   // bit clock rising event
   logic        fall;   // bit clock falling event
   logic [10:0] idx;    // bit index at this rise
   logic [10:0] nxt;    // bit index after this fall
   logic [2:0]  rxi;    // {active, channel, unused} for the received bit
   logic [2:0]  txi;    // {active, channel, data} for the sent bit

   // clock pins and toggle share one synchroniser; edges come from stage two vs three
   ap_sync #(.W(3)) u_pin_sync
   (
      .clk    (link_clk),
      .rstn   (link_rstn),
      .d      ({bit_clock_i, audio_frame_clock_i, lnk.req_tgl}),
      .q      ({bclk_s, fs_s, req_s}),
      .q_prev ({bclk_p, fs_p, req_p})
   );

   // configuration is a level group; it may only change while the port is off
   ap_sync #(.W($bits(ap_cfg_t) + 1)) u_cfg_sync
   (
      .clk    (link_clk),
      .rstn   (link_rstn),
      .d      ({lnk.cfg, pcm_serial_in}),
      .q      ({cfg, sd_s}),
      .q_prev ()
   );

   // slot lookup: is bit n carrying a sample bit, of which channel, and its value
   function automatic logic [2:0] ap_slot(input logic [10:0] bn, input logic [15:0] l,
                                          input logic [15:0] r, input logic [4:0] sln,
                                          input logic [4:0] wd);
      logic        ch;
      logic [10:0] pos;
      logic [15:0] word;
      logic [3:0]  b;
      ch   = (bn >= 11'(sln));
      pos  = ch ? bn - 11'(sln) : bn;
      word = ch ? r : l;
      b    = 4'(wd - 5'd1 - 5'(pos));
      if (bn < 11'({sln, 1'b0}) && pos < 11'(wd))
         ap_slot = {1'b1, ch, word[b]}; // msb first within each slot
      else
         ap_slot = {1'b0, ch, 1'b0};
   endfunction

   // next-state logic
   always_comb
   begin
      n    = q;
      w    = cfg.wide ? 5'd16 : 5'd8;
      sl   = cfg.i2s ? 5'(`AP_I2S_SLOT_BITS) : w;
      len  = cfg.i2s ? 12'(`AP_I2S_FRAME_BITS) : (12'(`AP_PCM_MIN_FRAME_BITS) << cfg.rate);
      last = 11'(len - 12'd1);
      // i2s half period fixed by the 256 fs / 32 fs ratio; pcm halves per rate step
      half = cfg.i2s ? 16'(`AP_I2S_BCLK_HALF)
                     : (16'(PCM_HALF_MIN) << (3'(`AP_RATE_MAX) - cfg.rate));
      rise = 1'b0;
      fall = 1'b0;
      idx  = q.bitcnt;
      nxt  = (q.bitcnt == last) ? 11'd0 : q.bitcnt + 11'd1;
      rxi  = 3'b000;
      txi  = ap_slot(nxt, (nxt == 11'd0) ? q.hold_l : q.act_l,
                     (nxt == 11'd0) ? q.hold_r : q.act_r, sl, w);

      // pin ownership: only the selected function in its own role drives
      n.bclk_oe_n = ~(cfg.en & cfg.master);
      n.fs_oe_n   = ~(cfg.en & cfg.master);
      if (cfg.en && cfg.i2s)
         n.sd_oe_n = 1'b0;

      // master clock only for i2s master; high impedance otherwise
      if (cfg.en && cfg.i2s && cfg.master)
      begin
         n.mclk      = ~q.mclk;
         n.mclk_oe_n = 1'b0;
      end
      else
      begin
         n.mclk      = 1'b0;
         n.mclk_oe_n = 1'b1;
      end

      // bit clock events
      if (!cfg.en)
      begin
         n.div     = '0;
         n.bclk    = 1'b0;
         n.fs      = 1'b0;
         n.bitcnt  = '0;
         n.fs_last = 1'b0;
         n.sd_oe_n = 1'b1;
      end
      else if (cfg.master)
      begin
         if (q.div == '0)
         begin
            n.div  = half - 16'd1;
            n.bclk = ~q.bclk;
            rise   = ~q.bclk;
            fall   = q.bclk;
         end
         else
            n.div = q.div - 16'd1;
      end
      else
      begin
         // slave: follow the outside bit clock
         rise = bclk_s & ~bclk_p;
         fall = ~bclk_s & bclk_p;
      end

      // slave frame alignment: the marker fixes the index of the current bit
      if (rise && !cfg.master)
      begin
         if (cfg.i2s)
         begin
            // a 32-bit frame is assumed; other ratios slip the slots
            if (fs_s != q.fs_last)
               idx = fs_s ? 11'(`AP_I2S_SLOT_BITS - 1) : 11'(`AP_I2S_FRAME_BITS - 1);
         end
         else
         begin
            unique case (cfg.framing)
               AP_TDM_EARLY:
                  if (fs_s && !q.fs_last)
                     idx = last; // pulse marks the bit before bit 0
               AP_TDM_ONBIT, AP_SSI:
                  if (fs_s && !q.fs_last)
                     idx = 11'd0; // marker starts with bit 0
               AP_TDM_LOW:
                  if (!fs_s && q.fs_last)
                     idx = 11'd0; // low-going marker on bit 0
            endcase
         end
      end

      // capture on the rising edge
      rxi = ap_slot(idx, 16'h0000, 16'h0000, sl, w);
      if (rise)
      begin
         n.bitcnt  = idx;
         n.fs_last = fs_s;
         if (rxi[2])
         begin
            if (rxi[1])
               n.rxw_r = {q.rxw_r[14:0], sd_s};
            else
               n.rxw_l = {q.rxw_l[14:0], sd_s};
         end
      end

      // launch on the falling edge
      if (fall)
      begin
         n.bitcnt = nxt;
         n.sdout  = txi[0];
         // i2s keeps the line driven; pcm releases it outside the two slots
         n.sd_oe_n = cfg.i2s ? 1'b0 : ~txi[2];
         if (cfg.i2s)
            n.fs = (nxt >= 11'(`AP_I2S_SLOT_BITS - 1)) && (nxt != last);
         else
         begin
            unique case (cfg.framing)
               AP_TDM_EARLY: n.fs = (nxt == last);
               AP_TDM_ONBIT: n.fs = (nxt == 11'd0);
               AP_TDM_LOW:   n.fs = (nxt != 11'd0);
               AP_SSI:       n.fs = (nxt < 11'(w));
            endcase
         end
         if (nxt == 11'd0)
         begin
            // frame boundary: publish received words, start new ones
            n.rx_l      = q.rxw_l;
            n.rx_r      = q.rxw_r;
            n.rxw_l     = '0;
            n.rxw_r     = '0;
            n.act_l     = q.hold_l;
            n.act_r     = q.hold_r;
            n.frame_tgl = ~q.frame_tgl;
         end
      end

      // hand-over from the bus side; words are stable while the toggle is unanswered
      if (req_s != req_p)
      begin
         n.hold_l  = lnk.tx_l;
         n.hold_r  = lnk.tx_r;
         n.ack_tgl = ~q.ack_tgl;
      end
   end

   // state register
   always_ff @(posedge link_clk)
   begin
      if (!link_rstn)
      begin
         q           <= '0;
         q.bclk_oe_n <= 1'b1;
         q.fs_oe_n   <= 1'b1;
         q.mclk_oe_n <= 1'b1;
         q.sd_oe_n   <= 1'b1;
      end
      else
         q <= n;
   end

   assign lnk.ack_tgl            = q.ack_tgl;
   assign lnk.frame_tgl          = q.frame_tgl;
   assign lnk.rx_l               = q.rx_l;
   assign lnk.rx_r               = q.rx_r;
   assign bit_clock_o            = q.bclk;
   assign bit_clock_oe_n         = q.bclk_oe_n;
   assign audio_frame_clock_o    = q.fs;
   assign audio_frame_clock_oe_n = q.fs_oe_n;
   assign master_clock_o         = q.mclk;
   assign master_clock_oe_n      = q.mclk_oe_n;
   assign pcm_serial_out         = q.sdout;
   assign pcm_serial_out_oe_n    = q.sd_oe_n;
endmodule

// -------------------------------------------------------------
// top: avalon-mm register slave on clk
// -------------------------------------------------------------
module ap_port import ap_pkg::*;
#(
   parameter int unsigned PCM_HALF_MIN = 1 // link clocks per half bit at the top pcm rate
)
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        link_clk,
   input  wire logic        link_rstn,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        bit_clock_i,
   output logic             bit_clock_o,
   output logic             bit_clock_oe_n,
   input  wire logic        audio_frame_clock_i,
   output logic             audio_frame_clock_o,
   output logic             audio_frame_clock_oe_n,
   output logic             master_clock_o,
   output logic             master_clock_oe_n,
   input  wire logic        pcm_serial_in,
   output logic             pcm_serial_out,
   output logic             pcm_serial_out_oe_n
);
   ap_top_t   q;     // state
   ap_top_t   n;     // next state
   ap_link_if lnk(); // carrier to the engine
   logic      ack_s; // synchronised toggles and previous values
   logic      ack_p;
   logic      frm_s;
   logic      frm_p;
   logic      acc;   // a request is being answered this cycle
   logic      txw;   // request is a write to a tx word

   // toggles from the link domain
   ap_sync #(.W(2)) u_tgl_sync
   (
      .clk    (clk),
      .rstn   (rstn),
      .d      ({lnk.ack_tgl, lnk.frame_tgl}),
      .q      ({ack_s, frm_s}),
      .q_prev ({ack_p, frm_p})
   );

   ap_engine #(.PCM_HALF_MIN(PCM_HALF_MIN)) u_engine
   (
      .link_clk               (link_clk),
      .link_rstn              (link_rstn),
      .lnk                    (lnk.lnk),
      .bit_clock_i            (bit_clock_i),
      .audio_frame_clock_i    (audio_frame_clock_i),
      .pcm_serial_in          (pcm_serial_in),
      .bit_clock_o            (bit_clock_o),
      .bit_clock_oe_n         (bit_clock_oe_n),
      .audio_frame_clock_o    (audio_frame_clock_o),
      .audio_frame_clock_oe_n (audio_frame_clock_oe_n),
      .master_clock_o         (master_clock_o),
      .master_clock_oe_n      (master_clock_oe_n),
      .pcm_serial_out         (pcm_serial_out),
      .pcm_serial_out_oe_n    (pcm_serial_out_oe_n)
   );

   // bus access, hand-over and receive capture
   always_comb
   begin
      n         = q;
      n.waitreq = 1'b1;
      txw = avs_write && (avs_address == `AP_OFS_TX_LEFT || avs_address == `AP_OFS_TX_RIGHT);
      // tx words are frozen during a hand-over, so such writes wait it out
      acc = (avs_read || avs_write) && q.waitreq && !(txw && q.busy);

      if (ack_s != ack_p)
         n.busy = 1'b0;

      if (acc)
      begin
         n.waitreq = 1'b0;
         n.rdata   = 32'h0000_0000; // unmapped reads return zero
         if (avs_read)
         begin
            unique case (avs_address)
               `AP_OFS_CTRL:
                  n.rdata[8:0] = q.cfg;
               `AP_OFS_STATUS:
               begin
                  n.rdata[`AP_ST_RX_READY] = q.rx_ready;
                  n.rdata[`AP_ST_TX_BUSY]  = q.busy;
                  n.rdata[`AP_ST_OVERRUN]  = q.overrun;
               end
               `AP_OFS_TX_LEFT:  n.rdata[15:0] = q.tx_l;
               `AP_OFS_TX_RIGHT: n.rdata[15:0] = q.tx_r;
               `AP_OFS_RX_LEFT:  n.rdata[15:0] = q.rx_l;
               `AP_OFS_RX_RIGHT: n.rdata[15:0] = q.rx_r;
               default:          n.rdata = 32'h0000_0000;
            endcase
         end
         else
         begin
            unique case (avs_address)
               `AP_OFS_CTRL:
               begin
                  n.cfg.en      = avs_writedata[`AP_CTRL_EN];
                  n.cfg.i2s     = avs_writedata[`AP_CTRL_I2S];
                  n.cfg.master  = avs_writedata[`AP_CTRL_MASTER];
                  n.cfg.framing = ap_frame_t'(avs_writedata[`AP_CTRL_FRM_HI:`AP_CTRL_FRM_LO]);
                  n.cfg.rate    = avs_writedata[`AP_CTRL_RATE_HI:`AP_CTRL_RATE_LO];
                  n.cfg.wide    = avs_writedata[`AP_CTRL_WIDE];
               end
               `AP_OFS_STATUS:
               begin
                  // write one to clear; a set in the same cycle follows and wins
                  if (avs_writedata[`AP_ST_RX_READY])
                     n.rx_ready = 1'b0;
                  if (avs_writedata[`AP_ST_OVERRUN])
                     n.overrun = 1'b0;
               end
               `AP_OFS_TX_LEFT:
                  n.tx_l = avs_writedata[15:0];
               `AP_OFS_TX_RIGHT:
               begin
                  // right word completes the pair and starts the hand-over
                  n.tx_r    = avs_writedata[15:0];
                  n.req_tgl = ~q.req_tgl;
                  n.busy    = 1'b1;
               end
               default:
                  n.tx_l = q.tx_l; // unmapped writes are answered and dropped
            endcase
         end
      end

      // a completed frame from the link; words are stable for a whole frame
      if (frm_s != frm_p)
      begin
         n.rx_l     = lnk.rx_l;
         n.rx_r     = lnk.rx_r;
         n.rx_ready = 1'b1;
         if (q.rx_ready)
            n.overrun = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         q         <= '0;
         q.cfg     <= ap_cfg_t'(`AP_CTRL_RESET);
         q.waitreq <= 1'b1;
      end
      else
         q <= n;
   end

   assign lnk.cfg         = q.cfg;
   assign lnk.tx_l        = q.tx_l;
   assign lnk.tx_r        = q.tx_r;
   assign lnk.req_tgl     = q.req_tgl;
   assign avs_readdata    = q.rdata;
   assign avs_waitrequest = q.waitreq;
endmodule

// >>> ap_regs.svh
// register map, field positions, reset values and timing counts of the audio port
// included by bare name; definitions only
`ifndef AP_REGS_SVH
`define AP_REGS_SVH

// -------------------------------------------------------------
// byte offsets on the register bus
// -------------------------------------------------------------
`define AP_OFS_CTRL      5'h00
`define AP_OFS_STATUS    5'h04
`define AP_OFS_TX_LEFT   5'h08
`define AP_OFS_TX_RIGHT  5'h0c
`define AP_OFS_RX_LEFT   5'h10
`define AP_OFS_RX_RIGHT  5'h14

// -------------------------------------------------------------
// control and status fields
// -------------------------------------------------------------
`define AP_CTRL_EN       0
`define AP_CTRL_I2S      1
`define AP_CTRL_MASTER   2
`define AP_CTRL_FRM_LO   3
`define AP_CTRL_FRM_HI   4
`define AP_CTRL_RATE_LO  5
`define AP_CTRL_RATE_HI  7
`define AP_CTRL_WIDE     8
`define AP_CTRL_RESET    9'h000
`define AP_ST_RX_READY   0
`define AP_ST_TX_BUSY    1
`define AP_ST_OVERRUN    2

// -------------------------------------------------------------
// frame geometry and clock ratios
// -------------------------------------------------------------
`define AP_I2S_FRAME_BITS     32
`define AP_I2S_SLOT_BITS      16
`define AP_MCLK_PER_FS        256
`define AP_PCM_MIN_FRAME_BITS 16
`define AP_RATE_MAX           7
// master clock toggles every link clock, so one bit clock half period in link clocks
`define AP_I2S_BCLK_HALF      (`AP_MCLK_PER_FS / `AP_I2S_FRAME_BITS)

`endif

// >>> ap_pkg.sv
// types shared by the audio port modules
// constants live in ap_regs.svh
package ap_pkg;

   // -------------------------------------------------------------
   // configuration
   // -------------------------------------------------------------
   typedef enum logic [1:0] {AP_TDM_EARLY, AP_TDM_ONBIT, AP_TDM_LOW, AP_SSI} ap_frame_t;

   typedef struct packed {
      logic      wide;     // 16-bit samples when set, else 8-bit
      logic [2:0] rate;    // pcm bit rate, 128 kb/s shifted left by rate
      ap_frame_t framing;  // pcm framing variant
      logic      master;   // port makes its own clocks
      logic      i2s;      // pins serve the i2s port
      logic      en;       // port running
   } ap_cfg_t;

   // -------------------------------------------------------------
   // link-side state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [15:0] div;       // bit clock half-period counter
      logic        bclk;      // generated bit clock
      logic        fs;        // generated frame clock
      logic        mclk;      // generated master clock
      logic        sdout;     // serial data out
      logic        bclk_oe_n; // pin drive enables, low drives
      logic        fs_oe_n;
      logic        mclk_oe_n;
      logic        sd_oe_n;
      logic [10:0] bitcnt;    // bit position in frame
      logic        fs_last;   // frame clock seen at previous rise
      logic [15:0] hold_l;    // words handed over by the bus side
      logic [15:0] hold_r;
      logic [15:0] act_l;     // words sent in the current frame
      logic [15:0] act_r;
      logic [15:0] rxw_l;     // words being received
      logic [15:0] rxw_r;
      logic [15:0] rx_l;      // last complete received words
      logic [15:0] rx_r;
      logic        frame_tgl; // flips once per frame
      logic        ack_tgl;   // flips once per accepted hand-over
   } ap_eng_t;

   // -------------------------------------------------------------
   // bus-side state
   // -------------------------------------------------------------
   typedef struct packed {
      ap_cfg_t     cfg;
      logic [15:0] tx_l;
      logic [15:0] tx_r;
      logic        req_tgl;
      logic        busy;
      logic [15:0] rx_l;
      logic [15:0] rx_r;
      logic        rx_ready;
      logic        overrun;
      logic        waitreq;
      logic [31:0] rdata;
   } ap_top_t;

endpackage

// >>> ap_link_if.sv
// carrier between the bus-side logic and the link-side engine
// the two sides sit in different clock domains; data is stable under handshake
`timescale 1ns/10ps
interface ap_link_if import ap_pkg::*; ;
   ap_cfg_t     cfg;       // quasi-static configuration
   logic [15:0] tx_l;      // words to send, stable while a hand-over is pending
   logic [15:0] tx_r;
   logic        req_tgl;   // flips to offer tx words
   logic        ack_tgl;   // flips when the engine took them
   logic        frame_tgl; // flips when rx words are new
   logic [15:0] rx_l;      // stable for a whole frame after a flip
   logic [15:0] rx_r;

   modport ctl (output cfg, tx_l, tx_r, req_tgl, input ack_tgl, frame_tgl, rx_l, rx_r);
   modport lnk (input cfg, tx_l, tx_r, req_tgl, output ack_tgl, frame_tgl, rx_l, rx_r);
endinterface

// >>> ap_sync.sv
// two-flop synchroniser plus one stage kept for edge detection
// assumes d is a level or a slow toggle from another domain
`timescale 1ns/10ps
module ap_sync #(parameter int unsigned W = 1)
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q,
   output logic [W-1:0]      q_prev
);
   typedef struct packed {
      logic [W-1:0] s1; // metastable stage, read only by s2
      logic [W-1:0] s2; // settled value
      logic [W-1:0] s3; // one cycle older, for edges
   } ap_sync_t;

   ap_sync_t st_q;
   ap_sync_t st_d;

   // shift chain
   always_comb
   begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign q      = st_q.s2;
   assign q_prev = st_q.s3;
endmodule

// >>> ap_port_props.sv
// assertions on ap_port: bus answers and generated i2s clocks
// bound to each ap_port, sees only its ports
`timescale 1ns/10ps
module ap_port_props
#(
   parameter int unsigned PCM_HALF_MIN = 1
)
(
   input logic        clk,
   input logic        rstn,
   input logic        link_clk,
   input logic        link_rstn,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic        bit_clock_o,
   input logic        bit_clock_oe_n,
   input logic        audio_frame_clock_o,
   input logic        audio_frame_clock_oe_n,
   input logic        master_clock_o,
   input logic        master_clock_oe_n,
   input logic        pcm_serial_out_oe_n
);
   // -------------------------------------------------------------
   // register bus
   // -------------------------------------------------------------
   property p_one; @(posedge clk) disable iff (!rstn) !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_ans; @(posedge clk) disable iff (!rstn) $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
   a_ans: assert property (p_ans) else $error("stray answer");
   property p_hold; @(posedge clk) disable iff (!rstn) avs_waitrequest |-> $stable(avs_readdata); endproperty
   a_hold: assert property (p_hold) else $error("readdata moved");
   // -------------------------------------------------------------
   // i2s master pins; gated by mclk drive so a disable mid-bit is not flagged
   // -------------------------------------------------------------
   sequence s_hi; (bit_clock_o || master_clock_oe_n)[*8]; endsequence
   property p_bclk; @(posedge link_clk) disable iff (!link_rstn)
      $rose(bit_clock_o) && !master_clock_oe_n |-> s_hi ##1 (!bit_clock_o || master_clock_oe_n); endproperty
   a_bclk: assert property (p_bclk) else $error("bit clock half");
   property p_mclk; @(posedge link_clk) disable iff (!link_rstn)
      !master_clock_oe_n && $past(!master_clock_oe_n) |-> master_clock_o != $past(master_clock_o); endproperty
   a_mclk: assert property (p_mclk) else $error("master clock");
   property p_fs; @(posedge link_clk) disable iff (!link_rstn)
      !master_clock_oe_n && $changed(audio_frame_clock_o) |-> $fell(bit_clock_o); endproperty
   a_fs: assert property (p_fs) else $error("frame edge");
   property p_drv; @(posedge link_clk) disable iff (!link_rstn)
      !master_clock_oe_n |-> !bit_clock_oe_n && !audio_frame_clock_oe_n; endproperty
   a_drv: assert property (p_drv) else $error("clocks not driven");
   property p_sd; @(posedge link_clk) disable iff (!link_rstn) !master_clock_oe_n |-> !pcm_serial_out_oe_n; endproperty
   a_sd: assert property (p_sd) else $error("data released");
endmodule
bind ap_port ap_port_props #(.PCM_HALF_MIN(PCM_HALF_MIN)) u_props (.*);

// >>> ap_codec_model.sv
// external i2s codec: makes the clocks when run, captures frames on the wire clocks
// assumes sck and ws are resolved pin levels
`timescale 1ns/10ps
module ap_codec_model
(
   input  logic        run,
   input  logic [31:0] word,
   input  logic        sck,
   input  logic        ws,
   input  logic        sdo,
   output logic        m_bclk,
   output logic        m_fs,
   output logic        m_sd,
   output logic [31:0] got,
   output logic [7:0]  n_frm
);
   logic [31:0] sr;   // sampled bits
   logic        ws_q; // frame clock at last rise
   initial {m_bclk, m_fs, m_sd, got, n_frm, sr, ws_q} = '0;
   // clock source, still between runs; data inverted when idle
   always @(posedge run)
   begin
      while (run)
         for (int b = 0; b < 32; b++)
         begin
            m_fs = (b >= 15 && b <= 30);
            m_sd = word[31-b];
            #1000 m_bclk = 1;
            #1000 m_bclk = 0;
         end
      m_sd = ~m_sd;
   end
   // frame ends on the bit where ws falls back low
   always @(posedge sck)
   begin
      sr   <= {sr[30:0], sdo};
      ws_q <= ws;
      if (ws_q && !ws)
      begin
         got   <= {sr[30:0], sdo};
         n_frm <= n_frm + 8'h01;
      end
   end
endmodule

// >>> tb_top.sv
// bench for ap_port: avalon tasks, i2s master, i2s slave, pcm pin use
// assumes ap_codec_model on the pins
`timescale 1ns/10ps
`include "ap_regs.svh"
module tb_top;
   logic        clk = 0, rstn = 0, link_clk = 0, link_rstn = 0, avs_read = 0, avs_write = 0, run = 0;
   logic [4:0]  avs_address = '0;
   logic [31:0] avs_writedata = '0, word = '0, avs_readdata, got, rd;
   logic        avs_waitrequest, bit_clock_o, bit_clock_oe_n, audio_frame_clock_o, audio_frame_clock_oe_n;
   logic        master_clock_o, master_clock_oe_n, pcm_serial_out, pcm_serial_out_oe_n, m_bclk, m_fs, m_sd;
   logic [7:0]  n_frm;
   int          fails = 0, n_tests = 0;
   wire         bit_clock_i = bit_clock_oe_n ? m_bclk : bit_clock_o;
   wire         audio_frame_clock_i = audio_frame_clock_oe_n ? m_fs : audio_frame_clock_o;
   wire         pcm_serial_in = m_sd;
   always #5 clk = ~clk;
   initial #3.7 forever #80 link_clk = ~link_clk;
   ap_port #(.PCM_HALF_MIN(1)) dut (.*);
   ap_codec_model u_cod (.run(run), .word(word), .sck(bit_clock_i), .ws(audio_frame_clock_i),
      .sdo(pcm_serial_out ^ pcm_serial_out_oe_n), .m_bclk(m_bclk), .m_fs(m_fs), .m_sd(m_sd), .got(got), .n_frm(n_frm));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   // holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int k = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 5000)
      begin
         @(posedge clk);
         k++;
      end
      fails += (k == 5000);
      rd = avs_readdata;
      avs_write <= 0;
      avs_read  <= 0;
      @(posedge clk);
   endtask
   task automatic frames(input int n);
      int k;
      logic [7:0] t;
      t = n_frm + n[7:0];
      for (k = 0; k < 40000 && n_frm !== t; k++)
         @(posedge clk);
      fails += (k == 40000);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #1000000;
      fails++;
      close_out;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1;
      repeat (48) @(posedge clk);
      link_rstn <= 1;
      @(posedge clk);
      bus(0, `AP_OFS_CTRL, 0);
      chk("ctrl reset", 0, rd);
      bus(1, `AP_OFS_CTRL, 32'h1f6);
      bus(0, `AP_OFS_CTRL, 0);
      chk("ctrl", 32'h1f6, rd);
      bus(0, 5'h1c, 0);
      chk("unmapped", 0, rd);
      bus(1, `AP_OFS_CTRL, 32'h106);
      bus(1, `AP_OFS_TX_LEFT, 32'ha5c3);
      bus(1, `AP_OFS_TX_RIGHT, 32'h1e69);
      bus(1, `AP_OFS_CTRL, 32'h107);
      frames(3);
      chk("master out", 32'ha5c31e69, got);
      chk("mclk oe", 0, master_clock_oe_n);
      bus(1, `AP_OFS_CTRL, 32'h106);
      bus(1, `AP_OFS_CTRL, 32'h102);
      bus(1, `AP_OFS_TX_LEFT, 32'h8001);
      bus(1, `AP_OFS_TX_RIGHT, 32'h7ffe);
      bus(1, `AP_OFS_STATUS, 1);
      bus(1, `AP_OFS_CTRL, 32'h103);
      word <= 32'h5a3c0ff1;
      run  <= 1;
      frames(3);
      chk("mclk hiz", 1, master_clock_oe_n);
      chk("slave out", 32'h80017ffe, got);
      bus(0, `AP_OFS_STATUS, 0);
      chk("rx ready", 1, rd & 1);
      bus(0, `AP_OFS_RX_LEFT, 0);
      chk("rx left", 32'h5a3c, rd);
      bus(0, `AP_OFS_RX_RIGHT, 0);
      chk("rx right", 32'h0ff1, rd);
      run <= 0;
      bus(1, `AP_OFS_CTRL, 32'h102);
      bus(1, `AP_OFS_CTRL, 32'h004);
      bus(1, `AP_OFS_CTRL, 32'h005);
      for (int k = 0; k < 500 && bit_clock_oe_n !== 1'b0; k++)
         @(posedge clk);
      chk("pcm bclk oe", 0, bit_clock_oe_n);
      chk("pcm mclk oe", 1, master_clock_oe_n);
      close_out;
   end
endmodule
